// *** common/tdp_cfg.svh ***
`ifndef TDP_CFG_SVH
`define TDP_CFG_SVH

`define TDP_OFF_CTRL     12'h000
`define TDP_OFF_STAT     12'h004
`define TDP_OFF_TXD      12'h008
`define TDP_OFF_RXD      12'h00C

`define TDP_CTRL_EN      0
`define TDP_CTRL_AUXEN   1
`define TDP_CTRL_ALT     2
`define TDP_CTRL_HDRX    3
`define TDP_CTRL_RST     4'h0
`define TDP_STAT_OVF     14

`define TDP_CLK_NS       10
`define TDP_PAR_HALF_NS  40
`define TDP_PAR_HALF_CYC (`TDP_PAR_HALF_NS / `TDP_CLK_NS)
`define TDP_ILV_HALF_CYC (`TDP_PAR_HALF_CYC / 2)
`define TDP_CAP_LAT      2'h2

`define TDP_FIFO_DEPTH   32
`define TDP_WORD_W       24
`define TDP_HALF_W       12
`define TDP_SPARE_BIT    12

`define TDP_OE_FULL      24'hFF_FFFF
`define TDP_OE_LOW       24'h00_0FFF
`define TDP_OE_LOW_SYNC  24'h00_1FFF

`endif

// *** common/tdp_pkg.sv ***
package tdp_pkg;

  typedef enum logic [3:0]
  {
    TDP_MODE_NONE           = 4'h0,
    TDP_FULL_DUPLEX_MODE    = 4'h1,
    TDP_FULL_DUPLEX_ALT     = 4'h2,
    TDP_HALF_DUPLEX_WIDE    = 4'h4,
    TDP_HALF_DUPLEX_NARROW  = 4'h7,
    TDP_HALF_DUPLEX_NAR_ALT = 4'h8
  } tdp_mode_t;

  typedef enum logic [1:0]
  {
    TDP_CFG_WAIT = 2'h0,
    TDP_CFG_RUN  = 2'h1,
    TDP_CFG_BAD  = 2'h3
  } tdp_cfg_state_t;

endpackage : tdp_pkg

// *** src/tdp_data_port.sv ***
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
`include "tdp_cfg.svh"

// Overview of operation
// - device makes the primary and auxiliary port clocks for the host.
// - transmit words are captured at the falling edge of the primary clock.
// - receive words are launched just after the primary clock rising edge.
// - alternate full duplex puts the receive sync marker on the auxiliary pin.
// - alternate narrow half duplex puts the sync marker on the spare upper pin.
// - duplex pin high gives full duplex, else width pin picks wide or narrow.
// - interpolation pins set interpolation and PLL together; 1x bypass only wide.
// - width pin is not read in full duplex; it drives the auxiliary clock.
// - interleaved modes need 2x or 4x interpolation.
// - interleaved transmit clock runs at twice the parallel rate.
// - full duplex always drives the auxiliary pin: a clock, or the sync marker in alternate.

module tdp_fifo #(
  parameter int WIDTH = `TDP_WORD_W,
  parameter int DEPTH = `TDP_FIFO_DEPTH
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_in,
  input  wire logic                     in_valid_in,
  output logic                          in_ready_out,
  input  wire logic [WIDTH-1:0]         in_data_in,
  output logic                          out_valid_out,
  input  wire logic                     out_ready_in,
  output logic [WIDTH-1:0]              out_data_out,
  output logic [$clog2(DEPTH):0]        count_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = in_valid_in && in_ready_out;
  wire pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = count != (AW+1)'(DEPTH);
  assign out_valid_out = count != '0;
  assign out_data_out  = mem[rd_ptr];
  assign count_out     = count;

  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
      rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
      if (push && !pop)
        count <= count + (AW+1)'(1);
      else if (pop && !push)
        count <= count - (AW+1)'(1);
    end
  end
endmodule : tdp_fifo

module tdp_data_port (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [11:0]        paddr_in,
  input  wire logic [31:0]        pwdata_in,
  output logic [31:0]             prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  input  wire logic               serial_port_select_in,
  input  wire logic               duplex_select_pin_in,
  input  wire logic               interpolation_select_high_in,
  input  wire logic               interpolation_select_low_in,
  input  wire logic               auxiliary_port_clock_in,
  output logic                    auxiliary_port_clock_out,
  output logic                    auxiliary_port_clock_oe_out,
  output logic                    primary_port_clock_out,
  input  wire logic [23:0]        bus_in,
  output logic [23:0]             bus_out,
  output logic [23:0]             bus_oe_out,
  output logic                    tx_ready_out,
  output tdp_pkg::tdp_mode_t      port_mode_out,
  output logic [1:0]              interp_rate_out,
  output logic [1:0]              pll_mult_out,
  output logic                    pll_bypass_out
);
  import tdp_pkg::*;

  logic [28:0] pin_meta;
  logic [28:0] pin_sync;
  wire  [28:0] pin_raw = {bus_in, serial_port_select_in, duplex_select_pin_in,
                          interpolation_select_high_in, interpolation_select_low_in,
                          auxiliary_port_clock_in};

  // pins are asynchronous to clk_sys_in
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire [23:0] bus_s = pin_sync[28:5];
  wire        ser_s = pin_sync[4];
  wire        dup_s = pin_sync[3];
  wire [1:0]  sel_s = pin_sync[2:1];
  wire        wid_s = pin_sync[0];

  tdp_cfg_state_t cfg_state;
  tdp_cfg_state_t next_cfg_state;
  logic [1:0]     cfg_cnt;
  logic           cfg_full;
  logic           cfg_narrow;
  logic [1:0]     cfg_interp;

  wire dec_narrow = !dup_s && wid_s;
  wire interp_ok  = (sel_s == 2'h1) || (sel_s == 2'h2) ||
                    (sel_s == 2'h0 && !dup_s && !wid_s);
  wire cfg_take   = (cfg_state == TDP_CFG_WAIT) && (cfg_cnt == `TDP_CAP_LAT);
  // without a serial port the pins are the only source; refuse otherwise
  assign next_cfg_state = !cfg_take ? cfg_state :
                          (ser_s || !interp_ok) ? TDP_CFG_BAD : TDP_CFG_RUN;

  // sampled once after the synchroniser has filled
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_state  <= TDP_CFG_WAIT;
      cfg_cnt    <= 2'h0;
      cfg_full   <= 1'b0;
      cfg_narrow <= 1'b0;
      cfg_interp <= 2'h0;
    end
    else
    begin
      cfg_state <= next_cfg_state;
      if (cfg_state == TDP_CFG_WAIT && !cfg_take)
        cfg_cnt <= cfg_cnt + 2'h1;
      if (cfg_take)
      begin
        cfg_full   <= dup_s;
        cfg_narrow <= dec_narrow;
        cfg_interp <= sel_s;
      end
    end
  end

  logic [3:0]  ctrl;
  logic [23:0] rx_word;
  logic        ovf;

  wire run       = cfg_state == TDP_CFG_RUN;
  wire port_on   = run && ctrl[`TDP_CTRL_EN];
  wire alt       = ctrl[`TDP_CTRL_ALT];
  wire ilv       = cfg_full || cfg_narrow;
  wire cap_en    = cfg_full || !ctrl[`TDP_CTRL_HDRX];
  wire launch_en = cfg_full || ctrl[`TDP_CTRL_HDRX];
  wire fd_alt    = cfg_full && alt;
  wire nar_alt   = cfg_narrow && alt;

  assign port_mode_out = !run ? TDP_MODE_NONE :
                         cfg_full ? (alt ? TDP_FULL_DUPLEX_ALT : TDP_FULL_DUPLEX_MODE) :
                         !cfg_narrow ? TDP_HALF_DUPLEX_WIDE :
                         alt ? TDP_HALF_DUPLEX_NAR_ALT : TDP_HALF_DUPLEX_NARROW;
  assign interp_rate_out = cfg_interp;
  assign pll_mult_out    = cfg_interp;
  assign pll_bypass_out  = run && cfg_interp == 2'h0;

  // primary clock divider; interleaved runs at half the half-period
  logic [2:0] div_cnt;
  logic [2:0] ref_cnt;
  logic       prim_clk;
  logic       ref_clk;
  logic [1:0] fall_d;

  wire [2:0] half_cyc = ilv ? 3'(`TDP_ILV_HALF_CYC) : 3'(`TDP_PAR_HALF_CYC);
  wire       tick     = port_on && div_cnt == half_cyc - 3'h1;
  wire       rise     = tick && !prim_clk;
  wire       fall     = tick && prim_clk;
  wire       ref_tick = run && ref_cnt == 3'(`TDP_PAR_HALF_CYC) - 3'h1;
  wire       cap_evt  = fall_d[1];

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_cnt  <= 3'h0;
      ref_cnt  <= 3'h0;
      prim_clk <= 1'b0;
      ref_clk  <= 1'b0;
      fall_d   <= 2'h0;
    end
    else
    begin
      div_cnt  <= (!port_on || tick) ? 3'h0 : div_cnt + 3'h1;
      ref_cnt  <= (!run || ref_tick) ? 3'h0 : ref_cnt + 3'h1;
      prim_clk <= port_on && (prim_clk ^ tick);
      ref_clk  <= run && (ref_clk ^ ref_tick);
      // bus sample lags the pin by two flops; delay the edge to match
      fall_d   <= {fall_d[0], fall && cap_en};
    end
  end

  assign primary_port_clock_out = prim_clk;

  // transmit capture and pairing, low word first
  logic        tx_half;
  logic [11:0] tx_lo;
  logic        push_v;
  logic [23:0] push_d;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [23:0] fifo_out_data;
  logic [5:0]  fifo_count;

  wire [11:0] tx_part = cfg_full ? bus_s[23:12] : bus_s[11:0];

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_half <= 1'b0;
      tx_lo   <= 12'h000;
      push_v  <= 1'b0;
      push_d  <= 24'h00_0000;
    end
    else
    begin
      push_v <= cap_evt && (!ilv || tx_half);
      if (!port_on)
        tx_half <= 1'b0;
      else if (cap_evt && ilv)
        tx_half <= !tx_half;
      if (cap_evt && ilv && !tx_half)
        tx_lo <= tx_part;
      if (cap_evt)
        push_d <= ilv ? {tx_part, tx_lo} : bus_s;
    end
  end

  // receive launch after the rising edge
  logic        rx_lsw;
  logic [23:0] rx_pair;
  logic [23:0] rx_bus;
  logic        receive_word_sync;

  wire [11:0] rx_part = rx_lsw ? rx_word[11:0] : rx_pair[23:12];

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_lsw            <= 1'b1;
      rx_pair           <= 24'h00_0000;
      rx_bus            <= 24'h00_0000;
      receive_word_sync <= 1'b0;
    end
    else if (!port_on)
    begin
      rx_lsw            <= 1'b1;
      receive_word_sync <= 1'b0;
    end
    else if (rise && launch_en)
    begin
      rx_lsw <= !ilv || !rx_lsw;
      if (rx_lsw)
        rx_pair <= rx_word;
      receive_word_sync <= ilv && rx_lsw && alt;
      if (!ilv)
        rx_bus <= rx_word;
      else
        rx_bus <= {11'h000, nar_alt && rx_lsw, rx_part};
    end
  end

  wire [23:0] oe_sel = !cfg_narrow && !cfg_full ? `TDP_OE_FULL :
                       nar_alt ? `TDP_OE_LOW_SYNC : `TDP_OE_LOW;
  assign bus_out    = rx_bus;
  assign bus_oe_out = (port_on && launch_en) ? oe_sel : 24'h00_0000;

  // aux pin: forced on in full duplex (sync marker if alternate), optional clock elsewhere
  assign auxiliary_port_clock_oe_out = run && (cfg_full || ctrl[`TDP_CTRL_AUXEN]);
  assign auxiliary_port_clock_out    = fd_alt ? receive_word_sync :
                                       (ref_clk ^ (cfg_full && ctrl[`TDP_CTRL_AUXEN]));

  // register bus, zero wait states
  wire acc    = psel_in && penable_in;
  wire hit_c  = paddr_in == `TDP_OFF_CTRL;
  wire hit_s  = paddr_in == `TDP_OFF_STAT;
  wire hit_t  = paddr_in == `TDP_OFF_TXD;
  wire hit_r  = paddr_in == `TDP_OFF_RXD;
  wire hit    = hit_c || hit_s || hit_t || hit_r;
  wire wr     = acc && pwrite_in;
  wire pop    = acc && !pwrite_in && hit_t;
  wire drop   = push_v && !fifo_in_ready;
  wire ovf_clr = wr && hit_s && pwdata_in[`TDP_STAT_OVF];

  wire [31:0] stat = {17'h0_0000, ovf, fifo_count, run, cfg_state == TDP_CFG_BAD,
                      cfg_interp, port_mode_out};
  wire [31:0] txd  = fifo_out_valid ? {8'h00, fifo_out_data} : 32'h0000_0000;

  assign pready_out  = 1'b1;
  assign pslverr_out = acc && !hit;
  assign prdata_out  = hit_c ? {28'h000_0000, ctrl} :
                       hit_s ? stat :
                       hit_t ? txd :
                       hit_r ? {8'h00, rx_word} : 32'h0000_0000;
  assign tx_ready_out = fifo_in_ready;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl    <= `TDP_CTRL_RST;
      rx_word <= 24'h00_0000;
      ovf     <= 1'b0;
    end
    else
    begin
      if (wr && hit_c)
        ctrl <= pwdata_in[3:0];
      if (wr && hit_r)
        rx_word <= pwdata_in[23:0];
      // a lost word in the clearing cycle still sets the flag
      ovf <= drop || (ovf && !ovf_clr);
    end
  end

  tdp_fifo #(
    .WIDTH (`TDP_WORD_W),
    .DEPTH (`TDP_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (push_v),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_d),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (pop),
    .out_data_out  (fifo_out_data),
    .count_out     (fifo_count)
  );

  // checks
  logic [3:0] still_cnt;
  logic       prim_q;
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      still_cnt <= 4'h0;
      prim_q    <= 1'b0;
    end
    else
    begin
      prim_q <= prim_clk;
      if (!port_on || prim_clk != prim_q)
        still_cnt <= 4'h0;
      else if (still_cnt != 4'hF)
        still_cnt <= still_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_clock_runs: assert property (still_cnt <= 4'(`TDP_PAR_HALF_CYC))
    else $error("primary clock stalled while port enabled");
  a_ilv_rate: assert property (ilv |-> still_cnt <= 4'(`TDP_ILV_HALF_CYC))
    else $error("interleaved clock too slow");
  a_tx_capture: assert property ((fall && cap_en && !ilv) |-> ##3 push_v)
    else $error("falling edge capture not pushed");
  a_rx_after_rise: assert property ($changed(rx_bus) |-> $past(rise))
    else $error("receive word moved off the rising edge");
  a_fd_sync: assert property (fd_alt && run |-> auxiliary_port_clock_out == receive_word_sync
                             && auxiliary_port_clock_oe_out)
    else $error("aux pin does not carry receive sync");
  a_spare_sync: assert property (receive_word_sync && nar_alt && port_on
                                 |-> bus_out[`TDP_SPARE_BIT] && bus_oe_out[`TDP_SPARE_BIT]
                                 && bus_out[11:0] == rx_pair[11:0])
    else $error("spare pin sync not on low word");
  a_serial_refused: assert property (cfg_take && ser_s |=> cfg_state == TDP_CFG_BAD)
    else $error("serial select high was accepted");
  a_mode_decode: assert property (cfg_take ##1 run |-> cfg_full == $past(dup_s)
                                  && cfg_narrow == (!$past(dup_s) && $past(wid_s)))
    else $error("mode pins decoded wrongly");
  a_interp_pll: assert property (run |-> pll_mult_out == interp_rate_out
                                 && (cfg_interp != 2'h3)
                                 && (pll_bypass_out == (cfg_interp == 2'h0)))
    else $error("interpolation and multiplier disagree");
  a_fd_no_width: assert property (run && cfg_full |-> !cfg_narrow)
    else $error("width pin read in full duplex");
  a_ilv_interp: assert property (run && ilv |-> cfg_interp != 2'h0)
    else $error("interleaved mode without interpolation");
  a_fd_aux_clock: assert property (run && cfg_full |-> auxiliary_port_clock_oe_out)
    else $error("aux clock not driven in full duplex");
  a_cfg_static: assert property (cfg_state != TDP_CFG_WAIT |=> $stable(cfg_full)
                                 && $stable(cfg_narrow) && $stable(cfg_interp))
    else $error("configuration changed after sampling");

  c_pair_push: cover property (ilv && cap_evt ##[1:20] push_v);
  c_wide_launch: cover property (port_on && !ilv && rise && launch_en);
  c_fifo_full: cover property (!fifo_in_ready);
  c_bad_cfg: cover property (cfg_state == TDP_CFG_BAD);
endmodule : tdp_data_port

// *** testbench/tdp_host_model.sv ***
`timescale 1ns/10ps

// host back end: drives only the bus bits that the device leaves free
module tdp_host_model (
  input  wire logic [23:0] word_in,
  input  wire logic [23:0] dev_bus_in,
  input  wire logic [23:0] dev_oe_in,
  input  wire logic        aux_dev_in,
  input  wire logic        aux_oe_in,
  input  wire logic        width_sel_in,
  output logic      [23:0] bus_out,
  output logic             aux_out
);
  // word held steady across the capture edge, device-driven bits read back
  assign bus_out = (dev_oe_in & dev_bus_in) | (~dev_oe_in & word_in);
  // width strap only seen while the device leaves the aux pin free
  assign aux_out = aux_oe_in ? aux_dev_in : width_sel_in;
endmodule : tdp_host_model

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`include "tdp_cfg.svh"

module testbench;
  import tdp_pkg::*;
  logic              clk_sys_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000, rd;
  logic              ssel = 1'b0, dup = 1'b0, wid = 1'b0, ih = 1'b0, il = 1'b1, er;
  logic [23:0]       word = 24'h00_0000;
  wire  [31:0]       prdata;
  wire               pready, pslverr, aux_in, aux_o, aux_oe, prim, txr, byp;
  wire  [23:0]       bus_in, bus_o, bus_oe;
  wire  [1:0]        irate, pmul;
  tdp_mode_t         mode;
  int                error_cnt = 0, checks_done = 0, n, i;
  logic [10:0]       e;
  // {serial select, duplex, width, interp high, interp low, mode, refused, bypass}
  logic [10:0]       tbl [11] = '{11'b00001_0100_0_0, 11'b00010_0100_0_0, 11'b00000_0100_0_1,
                                  11'b00101_0111_0_0, 11'b00110_0111_0_0, 11'b01101_0001_0_0,
                                  11'b01010_0001_0_0, 11'b00100_0000_1_0, 11'b01000_0000_1_0,
                                  11'b10001_0000_1_0, 11'b00011_0000_1_0};

  always #5 clk_sys_in = ~clk_sys_in;

  tdp_data_port i_tdp_data_port (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .serial_port_select_in(ssel),
    .duplex_select_pin_in(dup), .interpolation_select_high_in(ih),
    .interpolation_select_low_in(il), .auxiliary_port_clock_in(aux_in),
    .auxiliary_port_clock_out(aux_o), .auxiliary_port_clock_oe_out(aux_oe),
    .primary_port_clock_out(prim), .bus_in(bus_in), .bus_out(bus_o), .bus_oe_out(bus_oe),
    .tx_ready_out(txr), .port_mode_out(mode), .interp_rate_out(irate),
    .pll_mult_out(pmul), .pll_bypass_out(byp));

  tdp_host_model i_tdp_host_model (
    .word_in(word), .dev_bus_in(bus_o), .dev_oe_in(bus_oe), .aux_dev_in(aux_o),
    .aux_oe_in(aux_oe), .width_sel_in(wid), .bus_out(bus_in), .aux_out(aux_in));

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // setup then access; pready, read data and error are taken at the closing rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys_in);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1)
      error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rise(output int c);
    c = 0;
    @(negedge clk_sys_in);
    while (prim !== 1'b0 && c < 200) begin @(negedge clk_sys_in); c++; end
    while (prim !== 1'b1 && c < 200) begin @(negedge clk_sys_in); c++; end
    if (c >= 200)
      error_cnt++;
  endtask : rise

  // low word must carry the marker, high word must not; first launch may be stale
  task automatic sync_pair(input logic fd);
    logic [1:0] s;
    int j;
    apb(1'b1, `TDP_OFF_RXD, 32'h007E_81D4);
    rise(n);
    for (j = 0; j < 2; j++)
    begin
      rise(n);
      s[j] = fd ? aux_o : bus_o[`TDP_SPARE_BIT];
      chk({s[j], bus_o[11:0]}, s[j] ? 13'h11D4 : 13'h07E8);
    end
    chk(s[0] ^ s[1], 1'b1);
  endtask : sync_pair

  // serial select stays low except in one of the four refusal entries
  task automatic cfg(input logic [4:0] p);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    {ssel, dup, wid, ih, il} <= p;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
  endtask : cfg

  initial
  begin
    repeat (40000) @(posedge clk_sys_in);
    error_cnt++;
    conclude();
  end

  initial
  begin
    for (i = 0; i < 11; i++)
    begin
      e = tbl[i];
      cfg(e[10:6]);
      apb(1'b0, `TDP_OFF_STAT, 32'h0000_0000);
      chk(rd[6], e[1]);
      if (!e[1])
      begin
        chk(rd[5:0], {e[7:6], e[5:2]});
        chk(mode, e[5:2]);
        chk(byp, e[0]);
        chk({irate, pmul}, {e[7:6], e[7:6]});
      end
    end
    $display("mode pin table done");
    cfg(5'b00001);
    apb(1'b1, `TDP_OFF_CTRL, 32'h0000_0009);
    rise(n);
    rise(n);
    chk(n + 1, 8);
    apb(1'b1, `TDP_OFF_RXD, 32'h00A5_C3E1);
    rise(n);
    @(negedge clk_sys_in);
    chk(bus_o, 24'hA5_C3E1);
    chk(bus_oe, 24'hFF_FFFF);
    @(posedge clk_sys_in);
    dup <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    chk(mode, TDP_HALF_DUPLEX_WIDE);
    dup <= 1'b0;
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("wide receive done");
    word <= 24'h5A_3C96;
    apb(1'b1, `TDP_OFF_CTRL, 32'h0000_0001);
    n = 0;
    while (txr !== 1'b0 && n < 1000) begin @(posedge clk_sys_in); n++; end
    repeat (20) @(posedge clk_sys_in);
    apb(1'b0, `TDP_OFF_STAT, 32'h0000_0000);
    chk(rd[14:8], 7'h60);
    apb(1'b1, `TDP_OFF_CTRL, 32'h0000_0000);
    for (i = 0; i < 32; i++)
    begin
      apb(1'b0, `TDP_OFF_TXD, 32'h0000_0000);
      chk(rd, {8'h00, 24'h5A_3C96});
    end
    apb(1'b0, `TDP_OFF_TXD, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, `TDP_OFF_STAT, 32'h0000_4000);
    apb(1'b0, `TDP_OFF_STAT, 32'h0000_0000);
    chk(rd[14:8], 7'h00);
    $display("wide transmit done");
    cfg(5'b01010);
    chk(aux_oe, 1'b1);
    apb(1'b1, `TDP_OFF_CTRL, 32'h0000_0001);
    rise(n);
    rise(n);
    chk(n + 1, 4);
    apb(1'b1, `TDP_OFF_CTRL, 32'h0000_0005);
    @(negedge clk_sys_in);
    chk(mode, TDP_FULL_DUPLEX_ALT);
    chk(aux_oe, 1'b1);
    sync_pair(1'b1);
    apb(1'b0, `TDP_OFF_TXD, 32'h0000_0000);
    chk(rd, 32'h005A_35A3);
    $display("full duplex done");
    cfg(5'b00101);
    apb(1'b1, `TDP_OFF_CTRL, 32'h0000_000D);
    repeat (4) @(posedge clk_sys_in);
    chk(mode, TDP_HALF_DUPLEX_NAR_ALT);
    chk(bus_oe, 24'h00_1FFF);
    sync_pair(1'b0);
    $display("narrow alternate done");
    conclude();
  end
endmodule : testbench
